// >>> logic/srs_pkg.sv
// Package of constants and types for the supply restart supervisor
//----------------------------------------------------------------------
// Functional notes
// - Over-current and over-temperature recover automatically
// - Overvoltage: three restarts, 1 s apart, 1 min window
// - Three failed restarts in window latch output off
// - Fewer than three in window resets count
// - Enable pin off then on restarts latch
// - Output command off then on restarts latch
// - Reinsertion or input power cycle restarts latch
// - Mode change to restart releases latch immediately
// - Off condition must last two seconds
// - Successful restart clears all alarms
// - Answer 0xBx and 0xAx plus strap bits
// - Three pulled-up straps select eight addresses
// - Accept broadcast writes to address zero
// - Broadcast read refused, invalid-command alarm set
// - Enable pin low disables main output
// - Analog program overrides bus setpoint unless invalid
// - Interlock must be connected for output
// - Output recycle releases the alert output
//----------------------------------------------------------------------
package srs_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_ALARM  = 8'h08;
   localparam logic [7:0] REG_I2C    = 8'h0c;
   localparam logic [7:0] REG_VSET   = 8'h10;
   // Control fields and reset values
   localparam int         CTRL_OP_ON   = 0;
   localparam int         CTRL_LATCH   = 1;
   localparam logic       OP_ON_RST    = 1'b1;
   localparam logic       LATCH_RST    = 1'b1;
   localparam logic [15:0] VSET_NOMINAL = 16'h0c00;
   // Alarm bit positions
   localparam int         AL_OV  = 0;
   localparam int         AL_OC  = 1;
   localparam int         AL_OT  = 2;
   localparam int         AL_INV = 3;
   localparam int         AL_W   = 4;
   // Synchronised pin positions
   localparam int         SY_OE   = 0;
   localparam int         SY_SEAT = 1;
   localparam int         SY_AC   = 2;
   localparam int         SY_ILKN = 3;
   localparam int         SY_OV   = 4;
   localparam int         SY_OC   = 5;
   localparam int         SY_OT   = 6;
   localparam int         SY_GOOD = 7;
   localparam int         SY_VPRG = 8;
   localparam int         SY_SCL  = 9;
   localparam int         SY_SDA  = 10;
   localparam int         SY_A0   = 11;
   localparam int         SY_ALRT = 14;
   localparam int         SY_W    = 15;
   // Timing: clock period, tick length and intervals in ms
   localparam int         CLK_NS       = 10;
   localparam int         TICK_NS      = 1000000;
   localparam int         TICK_CYC_DEF = TICK_NS / CLK_NS;
   localparam logic [15:0] RESTART_MS  = 16'd1000;
   localparam logic [15:0] WINDOW_MS   = 16'd60000;
   localparam logic [15:0] OFF_MS      = 16'd2000;
   localparam logic [1:0]  MAX_TRIES   = 2'd3;
   // Serial address prefixes
   localparam logic [3:0] PFX_MCU  = 4'hb;
   localparam logic [3:0] PFX_MEM  = 4'ha;
   localparam logic [7:0] BCAST_WR = 8'h00;
   localparam logic [7:0] BCAST_RD = 8'h01;
   localparam logic [3:0] BITS_BYTE = 4'd8;
   // State enumerations
   typedef enum logic [1:0] {S_RUN, S_DELAY, S_LATCH} srs_sup_e;
   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_WDAT, I_RDAT, I_RACK} srs_i2c_e;
endpackage : srs_pkg

// >>> logic/srs_supervisor.sv
// Restart supervisor, serial address decoder and AHB-Lite register slave
module srs_supervisor
   import srs_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYC_DEF            // Cycles per 1 ms tick
)(
   input  wire logic        mclk_i,                       // System clock
   input  wire logic        nrst_i,                       // Sync reset, active low
   input  wire logic        hsel_i,                       // AHB select
   input  wire logic [7:0]  haddr_i,                      // AHB byte address
   input  wire logic [1:0]  htrans_i,                     // AHB transfer type
   input  wire logic        hwrite_i,                     // AHB write
   input  wire logic [2:0]  hsize_i,                      // AHB size
   input  wire logic        hready_i,                     // AHB bus ready
   input  wire logic [31:0] hwdata_i,                     // AHB write data
   output logic      [31:0] hrdata_o,                     // AHB read data
   output logic             hreadyout_o,                  // AHB slave ready
   output logic             hresp_o,                      // AHB response
   input  wire logic        output_enable_pin_i,          // Remote on/off pin
   input  wire logic        seated_i,                     // Module inserted
   input  wire logic        input_power_ok_i,             // Input power present
   input  wire logic        interlock_n_i,                // Low when interlock connected
   input  wire logic        ov_fault_i,                   // Overvoltage shutdown
   input  wire logic        oc_fault_i,                   // Over-current shutdown
   input  wire logic        ot_fault_i,                   // Over-temperature shutdown
   input  wire logic        output_good_i,                // Output in regulation
   input  wire logic        vprog_valid_i,                // Analog program below 3 V
   input  wire logic        address_strap_bit2_i,         // Address strap 2
   input  wire logic        address_strap_bit1_i,         // Address strap 1
   input  wire logic        address_strap_bit0_i,         // Address strap 0
   input  wire logic        scl_i,                        // Serial clock
   input  wire logic        sda_i,                        // Serial data in
   output logic             sda_o,                        // Serial data out
   output logic             sda_oe_o,                     // Serial data drive
   input  wire logic        host_alert_output_i,          // Alert wire level
   output logic             host_alert_output_o,          // Alert out level
   output logic             host_alert_output_oe_o,       // Alert drive
   output logic             main_output_on_o,             // Main output enable
   output logic             vout_use_pin_o,               // Setpoint from analog pin
   output logic      [15:0] vout_setpoint_o,              // Bus setpoint
   output logic             mem_select_o                  // Companion memory addressed
);

   //----------------------------------------------------------------------
   // State record
   //----------------------------------------------------------------------
   typedef struct packed {
      logic [SY_W-1:0] sync1;      // First sync stage
      logic [SY_W-1:0] sync2;      // Second sync stage
      logic [16:0]     tick;       // Tick prescaler
      srs_sup_e        st;         // Supervisor state
      logic [1:0]      tries;      // Overvoltage count
      logic [15:0]     dly;        // Restart delay timer
      logic [15:0]     win;        // Window timer
      logic            win_run;    // Window open
      logic [15:0]     off;        // Off-time timer
      logic            good_wait;  // Awaiting good output
      logic            op_on;      // Command output on
      logic            latch_mode; // Latch after three tries
      logic [15:0]     vset;       // Bus setpoint
      logic [AL_W-1:0] alarm;      // Sticky alarms
      logic            alert;      // Alert asserted
      logic            pin_off;    // Pin seen off
      logic            cmd_off;    // Command seen off
      logic            main_on;    // Main output
      srs_i2c_e        ist;        // Serial state
      logic [3:0]      bitcnt;     // Bit counter
      logic [7:0]      shreg;      // Shift register
      logic            rd_mode;    // Read transaction
      logic            mem_sel;    // Memory addressed
      logic            sda_oe;     // Drive data low
      logic [7:0]      rx_byte;    // Last received byte
      logic [7:0]      rx_cnt;     // Received byte count
      logic            wr_pend;    // Write data phase
      logic [7:0]      wa;         // Write address
      logic [31:0]     hrdata;     // Read data
      logic            scl_p;      // Clock, previous sample
      logic            sda_p;      // Data, previous sample
   } srs_state_s;

   srs_state_s q;                  // Registered state
   srs_state_s d;                  // Next state
   logic       bcast_rd;           // Broadcast read seen
   logic       addr_hit;           // Own address acked
   logic       latch_rel;          // Latch released

   //----------------------------------------------------------------------
   // Register read multiplexer
   //----------------------------------------------------------------------
   function automatic logic [31:0] rd_mux(input logic [7:0] a, input srs_state_s s);
      logic [31:0] r;
      r = 32'h0;
      if (a == REG_CTRL)
         r = {30'h0, s.latch_mode, s.op_on};
      else if (a == REG_STATUS)
         r = {16'h0, s.sync2[SY_ALRT], s.sync2[SY_A0+2 -: 3], s.alert, s.main_on,
              s.win_run, s.good_wait, 2'h0, s.tries, 2'h0, s.st};
      else if (a == REG_ALARM)
         r = {28'h0, s.alarm};
      else if (a == REG_I2C)
         r = {16'h0, s.rx_cnt, s.rx_byte};
      else if (a == REG_VSET)
         r = {16'h0, s.vset};
      return r;
   endfunction

   //----------------------------------------------------------------------
   // Next-state logic
   //----------------------------------------------------------------------
   always_comb
   begin
      logic [SY_W-1:0] s;
      logic            tick_p, take, ctrl_wr, scl_r, scl_f, start, stop, off_cond, en;
      logic [AL_W-1:0] al_set, al_clr;
      logic [1:0]      nt;
      s        = q.sync2;
      d        = q;
      bcast_rd = 1'b0;
      addr_hit = 1'b0;
      latch_rel = 1'b0;
      al_set   = '0;
      al_clr   = '0;
      nt       = 2'd0;
      {tick_p, take, ctrl_wr, scl_r, scl_f, start, stop, off_cond, en} = '0;
      // Two-stage pin synchronisers
      d.sync1 = {host_alert_output_i, address_strap_bit2_i, address_strap_bit1_i, address_strap_bit0_i,
                 sda_i, scl_i, vprog_valid_i, output_good_i, ot_fault_i, oc_fault_i, ov_fault_i,
                 interlock_n_i, input_power_ok_i, seated_i, output_enable_pin_i};
      d.sync2 = q.sync1;
      // Millisecond tick from the system clock
      tick_p = (q.tick == 17'(TICK_CYC - 1));
      d.tick = tick_p ? 17'h0 : q.tick + 17'h1;
      // AHB address phase
      take      = hsel_i && hready_i && htrans_i[1] && (hsize_i == 3'h2);
      d.wr_pend = take && hwrite_i;
      d.wa      = haddr_i;
      d.hrdata  = (take && !hwrite_i) ? rd_mux(haddr_i, q) : 32'h0;
      ctrl_wr   = q.wr_pend && (q.wa == REG_CTRL);
      // AHB data phase writes
      if (ctrl_wr)
      begin
         d.op_on      = hwdata_i[CTRL_OP_ON];
         d.latch_mode = hwdata_i[CTRL_LATCH];
      end
      if (q.wr_pend && (q.wa == REG_ALARM))
         al_clr = hwdata_i[AL_W-1:0];
      // Analog program overrides; bus setpoint only when ignored
      if (q.wr_pend && (q.wa == REG_VSET) && !s[SY_VPRG])
         d.vset = hwdata_i[15:0];
      // Over-current and over-temperature set alarms and gate output only
      al_set[AL_OC] = s[SY_OC];
      al_set[AL_OT] = s[SY_OT];
      // Any off condition for latch release
      off_cond = !s[SY_OE] || !q.op_on || !s[SY_SEAT] || !s[SY_AC];
      // Window expiry resets the count
      if (q.win_run && tick_p)
         d.win = q.win + 16'h1;
      if (q.win_run && tick_p && (q.win == WINDOW_MS - 16'h1) && (q.st != S_LATCH))
      begin
         d.win_run = 1'b0;
         d.tries   = 2'd0;
      end
      // Supervisor sequence
      case (q.st)
         S_RUN:
         begin
            if (s[SY_OV] && q.main_on)
            begin
               // Count overvoltage shutdowns in the window
               al_set[AL_OV] = 1'b1;
               nt            = q.win_run ? q.tries + 2'd1 : 2'd1;
               d.tries       = nt;
               if (!q.win_run)
               begin
                  d.win_run = 1'b1;
                  d.win     = 16'h0;
               end
               d.dly = 16'h0;
               // Third failure inside window latches
               d.st  = (q.latch_mode && nt == MAX_TRIES) ? S_LATCH : S_DELAY;
               d.off = 16'h0;
            end
         end
         S_DELAY:
         begin
            // One second between attempts
            if (tick_p)
               d.dly = q.dly + 16'h1;
            if (tick_p && q.dly == RESTART_MS - 16'h1)
            begin
               d.st        = S_RUN;
               d.good_wait = 1'b1;
            end
         end
         S_LATCH:
         begin
            // Off time measured and held at two seconds
            if (!off_cond)
               d.off = 16'h0;
            else if (tick_p && q.off != OFF_MS)
               d.off = q.off + 16'h1;
            // Pin, command, reinsertion or power recycle
            if (!off_cond && q.off == OFF_MS)
               latch_rel = 1'b1;
            // Mode change to restart needs no off time
            if (ctrl_wr && !hwdata_i[CTRL_LATCH])
               latch_rel = 1'b1;
            if (latch_rel)
            begin
               d.st        = S_RUN;
               d.tries     = 2'd0;
               d.win_run   = 1'b0;
               d.good_wait = 1'b1;
            end
         end
         default:
            d.st = S_RUN;
      endcase
      // Output gating: pin high, interlock made, no shutdown
      en = (q.st == S_RUN) && s[SY_OE] && q.op_on && !s[SY_ILKN] && s[SY_AC] && s[SY_SEAT]
           && !s[SY_OV] && !s[SY_OC] && !s[SY_OT];
      d.main_on = en;
      // Successful restart clears every alarm
      if (q.good_wait && q.main_on && s[SY_GOOD])
      begin
         d.good_wait = 1'b0;
         al_clr      = '1;
      end
      // Serial edges, taken from the second stage only
      d.scl_p = s[SY_SCL];
      d.sda_p = s[SY_SDA];
      scl_r   = s[SY_SCL] && !q.scl_p;
      scl_f   = !s[SY_SCL] && q.scl_p;
      start   = s[SY_SCL] && q.scl_p && q.sda_p && !s[SY_SDA];
      stop    = s[SY_SCL] && q.scl_p && !q.sda_p && s[SY_SDA];
      // Shift one bit per rising clock
      if (scl_r && (q.ist != I_IDLE))
      begin
         d.shreg  = {q.shreg[6:0], s[SY_SDA]};
         d.bitcnt = q.bitcnt + 4'h1;
      end
      // Byte engine, acting on falling clocks
      if (scl_f)
      begin
         case (q.ist)
            I_ADDR:
            begin
               if (q.bitcnt == BITS_BYTE)
               begin
                  // Own strapped address broadcast write
                  addr_hit  = (q.shreg[7:1] == {PFX_MCU, s[SY_A0+2 -: 3]}) || (q.shreg == BCAST_WR);
                  bcast_rd  = (q.shreg == BCAST_RD);                       // Refused
                  d.mem_sel = (q.shreg[7:1] == {PFX_MEM, s[SY_A0+2 -: 3]}); // Memory answers
                  d.rd_mode = q.shreg[0];
                  d.sda_oe  = addr_hit;
                  d.ist     = addr_hit ? I_ACK : I_IDLE;
               end
            end
            I_ACK:
            begin
               // Drive zero data on reads, release on writes
               d.sda_oe = q.rd_mode;
               d.ist    = q.rd_mode ? I_RDAT : I_WDAT;
               d.bitcnt = 4'h0;
            end
            I_WDAT:
            begin
               // Data byte stored, then acknowledged
               if (q.bitcnt == BITS_BYTE)
               begin
                  d.rx_byte = q.shreg;
                  d.rx_cnt  = q.rx_cnt + 8'h1;
                  d.sda_oe  = 1'b1;
                  d.ist     = I_ACK;
               end
            end
            I_RDAT:
            begin
               if (q.bitcnt == BITS_BYTE)
               begin
                  d.sda_oe = 1'b0;
                  d.ist    = I_RACK;
               end
            end
            I_RACK:
            begin
               // Host low continues the read, high ends it
               d.sda_oe = !q.shreg[0];
               d.ist    = q.shreg[0] ? I_IDLE : I_RDAT;
               d.bitcnt = 4'h0;
            end
            default:
               d.ist = q.ist;
         endcase
      end
      // Start and stop restart the byte engine
      if (start || stop)
      begin
         d.ist     = start ? I_ADDR : I_IDLE;
         d.bitcnt  = 4'h0;
         d.sda_oe  = 1'b0;
         d.mem_sel = 1'b0;
      end
      al_set[AL_INV] = bcast_rd;
      d.alarm   = (q.alarm & ~al_clr) | al_set;
      // Off seen on pin or command, then output back on
      d.pin_off = q.pin_off || !s[SY_OE];
      d.cmd_off = q.cmd_off || !q.op_on;
      if ((q.pin_off || q.cmd_off) && q.main_on)
         {d.alert, d.pin_off, d.cmd_off} = 3'h0;
      // A new alarm raises the alert; set wins
      if ((al_set & ~q.alarm) != '0)
         d.alert = 1'b1;
   end

   //----------------------------------------------------------------------
   // State register
   //----------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         q            <= '0;
         q.st         <= S_RUN;
         q.ist        <= I_IDLE;
         q.op_on      <= OP_ON_RST;
         q.latch_mode <= LATCH_RST;
         q.vset       <= VSET_NOMINAL;
      end
      else
         q <= d;
   end

   // Outputs from the state record; bus ready and response are constants
   assign hrdata_o               = q.hrdata;          // Read data flop
   assign hreadyout_o            = 1'b1;              // No wait states
   assign hresp_o                = 1'b0;              // Always OKAY
   assign sda_o                  = !q.sda_oe;         // Low only when driving
   assign sda_oe_o               = q.sda_oe;          // Data drive
   assign host_alert_output_o    = !q.alert;          // Low while alert
   assign host_alert_output_oe_o = q.alert;           // Open drain
   assign main_output_on_o       = q.main_on;         // Gated output
   assign vout_use_pin_o         = q.sync2[SY_VPRG];
   assign vout_setpoint_o        = q.vset;            // Bus setpoint
   assign mem_select_o           = q.mem_sel;         // Memory addressed

   //----------------------------------------------------------------------
   // Assertions and covers
   //----------------------------------------------------------------------
   default clocking cb_chk @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   property p_pin_gate; !q.sync2[SY_OE] |=> !main_output_on_o; endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("Main output on with enable pin low");
   property p_ilk_gate; q.sync2[SY_ILKN] |=> !main_output_on_o; endproperty
   a_ilk_gate: assert property (p_ilk_gate) else $error("Main output on with interlock open");
   property p_latch_off; (q.st == S_LATCH) |-> !main_output_on_o; endproperty
   a_latch_off: assert property (p_latch_off) else $error("Main output on while latched");
   property p_oc_alarm; q.sync2[SY_OC] |=> q.alarm[AL_OC]; endproperty
   a_oc_alarm: assert property (p_oc_alarm) else $error("Over-current alarm not set");
   property p_addr_ack; addr_hit |=> sda_oe_o; endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("Own address not acknowledged");
   property p_bcast_rd; bcast_rd |=> (q.alarm[AL_INV] && !sda_oe_o); endproperty
   a_bcast_rd: assert property (p_bcast_rd) else $error("Broadcast read not refused");
   property p_release; latch_rel |=> ((q.st == S_RUN) && (q.tries == 2'd0)); endproperty
   a_release: assert property (p_release) else $error("Latch release did not restart");
   c_latch: cover property ((q.st == S_LATCH) ##1 (q.st == S_RUN));
   c_bcast: cover property (bcast_rd);
   c_ack: cover property (addr_hit);
endmodule // srs_supervisor

// >>> verif/srs_host_model.sv
// Behavioural host controller on the two-wire management bus
module srs_host_model
(
   output logic      scl_o,        // Serial clock, host owned
   output logic      sda_low_o,    // High while host pulls data low
   input  wire logic sda_i         // Resolved data wire
);
   timeunit 1ns;
   timeprecision 100ps;
   //----------------------------------------------------------------
   // Link timing
   //----------------------------------------------------------------
   localparam int Q_NS = 20;       // Quarter of the 80 ns link period
   // Bus idles released, clock standing high
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // START, address byte MSB first, ack bit, STOP
   task automatic send_addr(input logic [7:0] addr, output logic ack);
      sda_low_o = 1'b1;
      #(2*Q_NS) scl_o = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         #Q_NS sda_low_o = ~addr[i];
         #Q_NS scl_o = 1'b1;
         #(2*Q_NS) scl_o = 1'b0;
      end
      #Q_NS sda_low_o = 1'b0;
      #Q_NS scl_o = 1'b1;
      #Q_NS ack = ~sda_i;
      #Q_NS scl_o = 1'b0;
      #Q_NS sda_low_o = 1'b1;
      #Q_NS scl_o = 1'b1;
      #(2*Q_NS) sda_low_o = 1'b0;
      #(8*Q_NS);
   endtask
endmodule // srs_host_model

// >>> verif/supply_restart_supervisor_tb.sv
// Self-checking bench for the supply restart supervisor
module supply_restart_supervisor_tb
   import srs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   //----------------------------------------------------------------
   // Stimulus and observation signals
   //----------------------------------------------------------------
   logic        mclk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic        hready, hresp, ack, scl, sda_low, sda_o, sda_oe;
   logic        oe = 1'b1, seat = 1'b1, pwr = 1'b1, ilk_n = 1'b0;
   logic        ov = 1'b0, oc = 1'b0, ot = 1'b0, good = 1'b0, vpv = 1'b0;
   logic        al_o, al_oe, mon, vpin, mem;
   logic [2:0]  strap = 3'h0;
   logic [15:0] vset;
   wire         sda_w = !(sda_low || (sda_oe && !sda_o)); // Pulled-up data
   wire         al_w = !(al_oe && !al_o);                 // Pulled-up alert
   int          n_mismatch = 0, cmp_count = 0, mem_cnt = 0, n;
   always #5 mclk_i = ~mclk_i;
   // Output regulates one cycle after enable; memory selects counted
   always @(posedge mclk_i)
   begin
      good <= mon;
      if (mem === 1'b1) mem_cnt <= mem_cnt + 1;
   end
   srs_supervisor #(.TICK_CYC(1)) i_dut (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready),
      .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .output_enable_pin_i(oe), .seated_i(seat), .input_power_ok_i(pwr),
      .interlock_n_i(ilk_n), .ov_fault_i(ov), .oc_fault_i(oc), .ot_fault_i(ot),
      .output_good_i(good), .vprog_valid_i(vpv), .address_strap_bit2_i(strap[2]),
      .address_strap_bit1_i(strap[1]), .address_strap_bit0_i(strap[0]),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .host_alert_output_i(al_w), .host_alert_output_o(al_o),
      .host_alert_output_oe_o(al_oe), .main_output_on_o(mon),
      .vout_use_pin_o(vpin), .vout_setpoint_o(vset), .mem_select_o(mem));
   srs_host_model i_host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));
   //----------------------------------------------------------------
   // Tasks
   //----------------------------------------------------------------
   // Compare and count
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge mclk_i);
   endtask
   // Single AHB-Lite word transfer, read data left in rd
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int w = 0;
      @(posedge mclk_i);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      @(posedge mclk_i);
      while (hready !== 1'b1 && w < 100)
      begin
         @(posedge mclk_i);
         w++;
      end
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge mclk_i);
      while (hready !== 1'b1 && w < 200)
      begin
         @(posedge mclk_i);
         w++;
      end
      rd = hrdata;
      check("bus answer", 32'h1, {31'h0, w < 200});
      check("hresp", 32'h0, {31'h0, hresp});
   endtask
   // Wait for main output level, optionally compare
   task automatic expect_out(input logic exp, input int max, input bit chk);
      int w = 0;
      while (mon !== exp && w < max)
      begin
         @(posedge mclk_i);
         w++;
      end
      if (chk) check("main output", {31'h0, exp}, {31'h0, mon});
   endtask
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   //----------------------------------------------------------------
   // Test sequence
   //----------------------------------------------------------------
   initial
   begin
      fork
         begin
            #900000;
            check("watchdog", 32'h0, 32'h1);
            complete_run();
         end
      join_none
      tick(3);
      nrst_i <= 1'b1;
      ahb(0, REG_CTRL, 0);
      check("ctrl", {30'h0, LATCH_RST, OP_ON_RST}, rd & 32'h3);
      ahb(0, REG_VSET, 0);
      check("vset", {16'h0, VSET_NOMINAL}, rd & 32'hffff);
      ahb(0, 8'h40, 0);
      check("unmapped", 32'h0, rd);
      $display("Test registers done");
      expect_out(1'b1, 300, 1);
      ilk_n <= 1'b1;
      expect_out(1'b0, 20, 1);
      ilk_n <= 1'b0;
      expect_out(1'b1, 300, 1);
      oe <= 1'b0;
      expect_out(1'b0, 20, 1);
      oe <= 1'b1;
      vpv <= 1'b1;
      tick(10);
      check("use pin", 32'h1, {31'h0, vpin});
      vpv <= 1'b0;
      ahb(1, REG_VSET, 32'h0b00);
      tick(10);
      check("use pin", 32'h0, {31'h0, vpin});
      check("setpoint", 32'h0b00, {16'h0, vset});
      $display("Test gating done");
      for (int s = 0; s < 8; s++)
      begin
         strap <= 3'(s);
         tick(10);
         i_host.send_addr({PFX_MCU, 3'(s), 1'b0}, ack);
         check("own ack", 32'h1, {31'h0, ack});
         i_host.send_addr({PFX_MCU, 3'(s) ^ 3'h1, 1'b0}, ack);
         check("foreign ack", 32'h0, {31'h0, ack});
         n = mem_cnt;
         i_host.send_addr({PFX_MEM, 3'(s), 1'b0}, ack);
         check("mem select", 32'h1, {31'h0, mem_cnt > n});
      end
      i_host.send_addr(BCAST_WR, ack);
      check("broadcast write ack", 32'h1, {31'h0, ack});
      i_host.send_addr(BCAST_RD, ack);
      check("broadcast read ack", 32'h0, {31'h0, ack});
      ahb(0, REG_ALARM, 0);
      check("invalid alarm", 32'h1, {31'h0, rd[AL_INV]});
      $display("Test addressing done");
      for (int f = 0; f < 2; f++)
      begin
         oc <= (f == 0);
         ot <= (f == 1);
         expect_out(1'b0, 50, 1);
         oc <= 1'b0;
         ot <= 1'b0;
         expect_out(1'b1, 3000, 1);
      end
      $display("Test auto restart done");
      for (int m = 0; m < 5; m++)
      begin
         for (int k = 0; k < 4; k++)
         begin
            expect_out(1'b1, 1500, 0);
            ov <= (mon === 1'b1);
            tick(5);
            ov <= 1'b0;
            if (k == 0) tick(500);
            if (k == 0) check("restart delay", 32'h0, {31'h0, mon});
         end
         tick(1500);
         check("latched", 32'h0, {31'h0, mon});
         if (m == 0)
         begin
            oe <= 1'b0;
            tick(100);
            oe <= 1'b1;
            tick(300);
            check("short off", 32'h0, {31'h0, mon});
         end
         case (m)
            0: oe <= 1'b0;
            1: ahb(1, REG_CTRL, 32'h2);
            2: seat <= 1'b0;
            3: pwr <= 1'b0;
            default: ahb(1, REG_CTRL, 32'h1);
         endcase
         if (m < 4) tick(2100);
         oe <= 1'b1;
         seat <= 1'b1;
         pwr <= 1'b1;
         if (m == 1) ahb(1, REG_CTRL, 32'h3);
         expect_out(1'b1, 300, 1);
         tick(50);
         ahb(0, REG_ALARM, 0);
         check("alarms", 32'h0, rd);
         if (m < 2) check("alert", 32'h1, {31'h0, al_w});
         $display("Test restart mechanism %0d done", m);
      end
      complete_run();
   end
endmodule // supply_restart_supervisor_tb
